//--- core/gpc_gpio_pin_ctrl.sv
// Purpose: Per-pin GPIO function, pad control, data and interrupt logic
// Assumes: One clock pclk, APB register access, pads sampled asynchronously
// Notes: Pins are banked in two 32-bit words; unused upper pins read zero except in the output data word
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - A three-bit trigger field picks rising, falling, both edges, high or low level; higher codes give no event.
// - With a pin's interrupt enable clear, its pending flag is never set and no request is forwarded.
// - With a pin's interrupt enable set, its pending flag sets whenever the selected trigger is seen.
// - A pending pin drives its irq_req only while its forward mask bit is one; the per-bank irq events ignore the mask.
// - A four-bit function field routes the pin to GPIO (code 1) or a peripheral; codes above 7 are reserved; reset zero.
// - A three-bit drive field picks one of eight pad drive levels and resets to the second level.
// - One bit enables the pad Schmitt input, reset cleared.
// - One bit enables the pull-down and separate bits each pull-up strength, all reset disabled.
// - Bit-set registers set the output data bits written as one and leave the rest.
// - Bit-clear registers clear the output data bits written as one and leave the rest.
// - Input data registers return sampled pin levels for pins with input enable set and zero for the rest, one bit per pin in two banked words.
// - Pending registers hold one interrupt flag per pin in two banked words.
module gpc_gpio_pin_ctrl
  import gpc_pkg::*;
#(
  parameter int NUM_PINS = 48,
  parameter int NUM_FUNCS = 8
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe,
  output logic [NUM_PINS-1:0] pad_ie,
  output logic [NUM_PINS-1:0] pad_schmitt,
  output logic [NUM_PINS-1:0] pad_pulldown,
  output logic [NUM_PINS-1:0] pad_pullup_weak,
  output logic [NUM_PINS-1:0] pad_pullup_strong,
  output logic [3*NUM_PINS-1:0] pad_drive_level,
  // Peripheral side, NUM_FUNCS signals per pin
  input wire logic [NUM_FUNCS*NUM_PINS-1:0] periph_out,
  input wire logic [NUM_FUNCS*NUM_PINS-1:0] periph_oe,
  output logic [NUM_PINS-1:0] periph_in,
  output logic [NUM_PINS-1:0] periph_sel_gpio,
  // Interrupt controller
  output logic [NUM_PINS-1:0] irq_req,
  output logic irq
);

  // Bus decode
  logic setup_hit;
  logic wr_en;
  logic in_ctl;
  logic [ADDR_W-1:0] ctl_rel;
  logic [5:0] ctl_idx;
  logic ready_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic [31:0] rd_d;
  logic err_d;

  // Shared state, padded to two full banks
  logic [31:0] ctl_q [64];
  logic [63:0] odat_q;
  logic [63:0] idat;
  logic [63:0] pend;
  logic [63:0] pend_set;
  logic [63:0] pend_clr;
  logic [63:0] bset;
  logic [63:0] bclr;
  logic [EVT_W-1:0] evt_stat_q;
  logic [EVT_W-1:0] evt_en_q;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;

  assign setup_hit = psel && !penable;
  // Write takes effect only at the access edge that samples pready high
  assign wr_en = psel && penable && ready_q && pwrite && clk_en;
  assign ctl_rel = paddr - CTL_BASE_OFS;
  assign ctl_idx = ctl_rel[7:2];
  assign in_ctl = (paddr >= CTL_BASE_OFS) && (paddr[1:0] == 2'b00) &&
                  (ctl_rel[ADDR_W-1:2] < NUM_PINS);

  // Read mux, evaluated in the setup cycle
  always_comb begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    if (in_ctl) begin
      rd_d = ctl_q[ctl_idx] & CTL_WMASK;
    end else begin
      case (paddr)
        ODAT_LO_OFS: rd_d = odat_q[31:0];
        ODAT_HI_OFS: rd_d = odat_q[63:32];
        IDAT_LO_OFS: rd_d = idat[31:0];
        IDAT_HI_OFS: rd_d = idat[63:32];
        PEND_LO_OFS: rd_d = pend[31:0];
        PEND_HI_OFS: rd_d = pend[63:32];
        EVT_STAT_OFS: rd_d = {{(32-EVT_W){1'b0}}, evt_stat_q};
        EVT_EN_OFS: rd_d = {{(32-EVT_W){1'b0}}, evt_en_q};
        // Write-only and unimplemented wake control read zero
        BSET_LO_OFS, BSET_HI_OFS, BCLR_LO_OFS, BCLR_HI_OFS,
        WAKE_CTL_OFS, EVT_CLR_OFS: rd_d = 32'h0000_0000;
        default: err_d = 1'b1;
      endcase
    end
  end

  // No wait states: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
    end else if (clk_en) begin
      ready_q <= setup_hit;
    end
  end

  // Read data captured at the setup edge, held until the next setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (clk_en && setup_hit) begin
      rdata_q <= pwrite ? 32'h0000_0000 : rd_d;
    end
  end

  // Error only pulses alongside pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (clk_en) begin
      err_q <= setup_hit && err_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;

  // Output data set and clear strobes
  always_comb begin
    bset = 64'h0;
    bclr = 64'h0;
    if (wr_en) begin
      case (paddr)
        BSET_LO_OFS: bset[31:0] = pwdata;
        BSET_HI_OFS: bset[63:32] = pwdata;
        BCLR_LO_OFS: bclr[31:0] = pwdata;
        BCLR_HI_OFS: bclr[63:32] = pwdata;
        default: ;
      endcase
    end
  end

  // Write-one-to-clear strobes for the flags
  always_comb begin
    pend_clr = 64'h0;
    evt_clr = '0;
    if (wr_en) begin
      case (paddr)
        PEND_LO_OFS: pend_clr[31:0] = pwdata;
        PEND_HI_OFS: pend_clr[63:32] = pwdata;
        EVT_CLR_OFS: evt_clr = pwdata[EVT_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odat_q <= 64'h0;
    end else if (clk_en) begin
      if (wr_en && paddr == ODAT_LO_OFS) begin
        odat_q[31:0] <= pwdata;
      end else if (wr_en && paddr == ODAT_HI_OFS) begin
        odat_q[63:32] <= pwdata;
      end else begin
        odat_q <= (odat_q | bset) & ~bclr;
      end
    end
  end

  // Block interrupt: sticky per-bank event, set beats clear
  assign evt_set[EVT_LO_BIT] = |pend_set[31:0];
  assign evt_set[EVT_HI_BIT] = |pend_set[63:32];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_stat_q <= '0;
    end else if (clk_en) begin
      evt_stat_q <= (evt_stat_q & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_en_q <= '0;
    end else if (clk_en && wr_en && paddr == EVT_EN_OFS) begin
      evt_en_q <= pwdata[EVT_W-1:0];
    end
  end

  // Uses the next status so a new event is not a cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(((evt_stat_q & ~evt_clr) | evt_set) & evt_en_q);
    end
  end

  // Per-pin logic
  for (genvar i = 0; i < 64; i++) begin : g_pin
    if (i < NUM_PINS) begin : g_real
      logic [1:0] sync_q;
      logic prev_q;
      logic pend_q;
      logic hit;
      logic [2:0] trig;
      logic [3:0] func;
      logic is_gpio;
      logic f_out;
      logic f_oe;
      logic [NUM_FUNCS-1:0] p_out;
      logic [NUM_FUNCS-1:0] p_oe;

      assign trig = ctl_q[i][TRIG_MSB:TRIG_LSB];
      assign func = ctl_q[i][FUNC_MSB:FUNC_LSB];
      assign is_gpio = (func == FUNC_GPIO);
      assign p_out = periph_out[i*NUM_FUNCS +: NUM_FUNCS];
      assign p_oe = periph_oe[i*NUM_FUNCS +: NUM_FUNCS];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctl_q[i] <= CTL_RESET;
        end else if (clk_en && wr_en && in_ctl && ctl_idx == 6'(i)) begin
          ctl_q[i] <= pwdata & CTL_WMASK;
        end
      end

      // Pad input is asynchronous to pclk
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_q <= 2'b00;
        end else if (clk_en) begin
          sync_q <= {sync_q[0], pad_in[i]};
        end
      end

      // Previous synced level for edge detection
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev_q <= 1'b0;
        end else if (clk_en) begin
          prev_q <= sync_q[1];
        end
      end

      // Trigger detect; reserved codes never fire
      always_comb begin
        case (trig)
          TRIG_RISE: hit = sync_q[1] && !prev_q;
          TRIG_FALL: hit = !sync_q[1] && prev_q;
          TRIG_BOTH: hit = sync_q[1] != prev_q;
          TRIG_HIGH: hit = sync_q[1];
          TRIG_LOW: hit = !sync_q[1];
          default: hit = 1'b0;
        endcase
      end

      // Set wins over a same-cycle clear, so no event is lost
      assign pend_set[i] = hit && ctl_q[i][IRQ_EN_BIT];
      assign pend[i] = pend_q;
      assign idat[i] = sync_q[1] && ctl_q[i][IN_EN_BIT];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pend_q <= 1'b0;
        end else if (clk_en) begin
          pend_q <= (pend_q & ~pend_clr[i]) | pend_set[i];
        end
      end

      // Function routing; reserved codes leave the pin undriven
      always_comb begin
        f_out = 1'b0;
        f_oe = 1'b0;
        if (is_gpio) begin
          f_out = odat_q[i];
          f_oe = ctl_q[i][OUT_EN_BIT];
        end else if (func <= FUNC_MAX && 32'(func) < NUM_FUNCS) begin
          f_out = p_out[func[2:0]];
          f_oe = p_oe[func[2:0]];
        end
      end

      // Data forced low while the driver is off
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pad_out[i] <= 1'b0;
          pad_oe[i] <= 1'b0;
        end else if (clk_en) begin
          pad_out[i] <= f_out && f_oe;
          pad_oe[i] <= f_oe;
        end
      end

      // Pad settings follow the control word one edge later
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pad_ie[i] <= 1'b0;
          pad_schmitt[i] <= 1'b0;
          pad_pulldown[i] <= 1'b0;
          pad_pullup_weak[i] <= 1'b0;
          pad_pullup_strong[i] <= 1'b0;
        end else if (clk_en) begin
          pad_ie[i] <= ctl_q[i][IN_EN_BIT];
          pad_schmitt[i] <= ctl_q[i][SCHMITT_BIT];
          pad_pulldown[i] <= ctl_q[i][PD_BIT];
          pad_pullup_weak[i] <= ctl_q[i][PU_WEAK_BIT];
          pad_pullup_strong[i] <= ctl_q[i][PU_STRONG_BIT];
        end
      end

      // Drive level resets to the second of eight steps
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pad_drive_level[3*i +: 3] <= CTL_RESET[DRV_MSB:DRV_LSB];
        end else if (clk_en) begin
          pad_drive_level[3*i +: 3] <= ctl_q[i][DRV_MSB:DRV_LSB];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          periph_in[i] <= 1'b0;
          periph_sel_gpio[i] <= 1'b0;
        end else if (clk_en) begin
          periph_in[i] <= sync_q[1] && !is_gpio;
          periph_sel_gpio[i] <= is_gpio;
        end
      end

      // Mask gates forwarding only; the flag itself stays
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_req[i] <= 1'b0;
        end else if (clk_en) begin
          irq_req[i] <= pend_q && ctl_q[i][IRQ_EN_BIT] &&
                        ctl_q[i][FWD_MASK_BIT];
        end
      end
    end else begin : g_none
      assign pend_set[i] = 1'b0;
      assign pend[i] = 1'b0;
      assign idat[i] = 1'b0;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctl_q[i] <= 32'h0000_0000;
        end else begin
          ctl_q[i] <= 32'h0000_0000;
        end
      end
    end
  end

endmodule : gpc_gpio_pin_ctrl

`default_nettype wire

//--- core/gpc_pkg.sv
// Purpose: Constants for the per-pin GPIO control and interrupt block
// Assumes: APB slave with 32-bit data, byte addresses of 12 bits
// Notes: Offsets are byte addresses of aligned 32-bit words
package gpc_pkg;
  localparam int ADDR_W = 12;
  // Register map
  localparam logic [11:0] CTL_BASE_OFS = 12'h00C;
  localparam logic [11:0] ODAT_LO_OFS = 12'h100;
  localparam logic [11:0] ODAT_HI_OFS = 12'h104;
  localparam logic [11:0] BSET_LO_OFS = 12'h108;
  localparam logic [11:0] BSET_HI_OFS = 12'h10C;
  localparam logic [11:0] BCLR_LO_OFS = 12'h110;
  localparam logic [11:0] BCLR_HI_OFS = 12'h114;
  localparam logic [11:0] IDAT_LO_OFS = 12'h118;
  localparam logic [11:0] IDAT_HI_OFS = 12'h11C;
  localparam logic [11:0] PEND_LO_OFS = 12'h120;
  localparam logic [11:0] PEND_HI_OFS = 12'h124;
  localparam logic [11:0] WAKE_CTL_OFS = 12'h140;
  localparam logic [11:0] EVT_STAT_OFS = 12'h180;
  localparam logic [11:0] EVT_EN_OFS = 12'h184;
  localparam logic [11:0] EVT_CLR_OFS = 12'h188;
  // Pin control field positions
  localparam int FWD_MASK_BIT = 25;
  localparam int TRIG_LSB = 21;
  localparam int TRIG_MSB = 23;
  localparam int IRQ_EN_BIT = 20;
  localparam int DRV_LSB = 12;
  localparam int DRV_MSB = 14;
  localparam int PU_STRONG_BIT = 11;
  localparam int PD_BIT = 9;
  localparam int PU_WEAK_BIT = 8;
  localparam int IN_EN_BIT = 7;
  localparam int OUT_EN_BIT = 6;
  localparam int SCHMITT_BIT = 5;
  localparam int FUNC_LSB = 0;
  localparam int FUNC_MSB = 3;
  // Writable bits and reset value of a pin control word
  localparam logic [31:0] CTL_WMASK = 32'h02F0_7BEF;
  localparam logic [31:0] CTL_RESET = 32'h0000_1000;
  // Function and trigger codes
  localparam logic [3:0] FUNC_GPIO = 4'h1;
  localparam logic [3:0] FUNC_MAX = 4'h7;
  localparam logic [2:0] TRIG_RISE = 3'h0;
  localparam logic [2:0] TRIG_FALL = 3'h1;
  localparam logic [2:0] TRIG_BOTH = 3'h2;
  localparam logic [2:0] TRIG_HIGH = 3'h3;
  localparam logic [2:0] TRIG_LOW = 3'h4;
  // Block event status bits
  localparam int EVT_W = 2;
  localparam int EVT_LO_BIT = 0;
  localparam int EVT_HI_BIT = 1;
endpackage : gpc_pkg

//--- tb/gpc_gpio_pin_ctrl_assertions.sv
// Purpose: Bus and pad checks for the GPIO pin block
// Assumes: clk_en held high
// Notes: Pad settings may only move after a completed write
`timescale 1ns/1ps
`default_nettype none
module gpc_gpio_pin_ctrl_assertions #(
  parameter int NUM_PINS = 48
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pads
  input wire logic [NUM_PINS-1:0] pad_out,
  input wire logic [NUM_PINS-1:0] pad_oe,
  input wire logic [NUM_PINS-1:0] pad_ie,
  input wire logic [NUM_PINS-1:0] pad_schmitt,
  input wire logic [NUM_PINS-1:0] pad_pulldown,
  input wire logic [NUM_PINS-1:0] pad_pullup_weak,
  input wire logic [NUM_PINS-1:0] pad_pullup_strong,
  input wire logic [3*NUM_PINS-1:0] pad_drive_level,
  input wire logic [NUM_PINS-1:0] periph_sel_gpio
);
  logic [11*NUM_PINS-1:0] cfg;
  // Peripheral pins move data freely, so only GPIO pins count there
  assign cfg = {pad_out & periph_sel_gpio, pad_oe & periph_sel_gpio,
    pad_ie, pad_schmitt, pad_pulldown, pad_pullup_weak, pad_pullup_strong,
    pad_drive_level, periph_sel_gpio};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_done; psel && penable && pready; endsequence
  property p_answer; s_setup |=> s_done; endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_in_access; pready |-> psel && penable; endproperty
  a_in_access: assert property (p_in_access) else $error("stray ready");
  property p_err_zero; pready && pslverr |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not 0");
  property p_out_gate; (pad_out & ~pad_oe) == '0; endproperty
  a_out_gate: assert property (p_out_gate)
    else $error("undriven out");
  property p_rst_vals;
    $rose(presetn) |-> pad_drive_level == {NUM_PINS{3'b001}} &&
      pad_schmitt == '0 && pad_pulldown == '0 && pad_pullup_weak == '0 &&
      pad_pullup_strong == '0 && periph_sel_gpio == '0;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("bad reset");
  // A refused write must leave every pad setting alone
  property p_cfg_by_write;
    $changed(cfg) |->
      $past(psel && penable && pready && pwrite && !pslverr, 2);
  endproperty
  a_cfg_by_write: assert property (p_cfg_by_write)
    else $error("pad moved");
endmodule : gpc_gpio_pin_ctrl_assertions
`default_nettype wire

//--- tb/gpc_pad_model.sv
// Purpose: Pad wire outside the GPIO block
// Assumes: Bench picks pins that an outside source drives
// Notes: Unheld pins toggle so a stale level cannot pass
`timescale 1ns/1ps
`default_nettype none
module gpc_pad_model #(
  parameter int N = 48
) (
  // Clock
  input wire logic pclk,
  // Block side
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pad_pd,
  input wire logic [N-1:0] pad_pu,
  // Outside source
  input wire logic [N-1:0] ext_en,
  input wire logic [N-1:0] ext_lvl,
  // Resolved level
  output logic [N-1:0] pad_in
);
  logic flt_q = 1'b0;
  always @(posedge pclk) flt_q <= ~flt_q;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_lvl[i];
      else if (pad_pd[i] | pad_pu[i]) pad_in[i] = pad_pu[i];
      else pad_in[i] = flt_q;
    end
  end
endmodule : gpc_pad_model
`default_nettype wire

//--- tb/gpc_gpio_pin_ctrl_tb.sv
// Purpose: Register and pad tests for the GPIO pin block
// Assumes: clk_en high, peripheral inputs idle except pin 1 function 0 (po[8], poe[8])
// Notes: Pins 2, 3 and 34 are driven from outside
`timescale 1ns/1ps
`default_nettype none
module gpc_gpio_pin_ctrl_tb import gpc_pkg::*;;
  localparam int NP = 48;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, err_q, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic [NP-1:0] pad_in, pad_out, pad_oe, pad_ie, sm, pd, puw, pus;
  logic [NP-1:0] sg, irq_req, p_in;
  logic [8*NP-1:0] po = '0, poe = '0;
  logic [NP-1:0] ext_en = 48'h0, ext_lvl = 48'h0;
  logic [3*NP-1:0] drv;
  int n_fail = 0, compares = 0;
  always #5 pclk = ~pclk;
  gpc_gpio_pin_ctrl dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_ie(pad_ie),
    .pad_schmitt(sm), .pad_pulldown(pd), .pad_pullup_weak(puw),
    .pad_pullup_strong(pus), .pad_drive_level(drv), .periph_out(po),
    .periph_oe(poe), .periph_in(p_in), .periph_sel_gpio(sg),
    .irq_req(irq_req), .irq(irq));
  gpc_pad_model #(.N(NP)) u_pads (.pclk(pclk), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pd(pd), .pad_pu(puw | pus), .ext_en(ext_en),
    .ext_lvl(ext_lvl), .pad_in(pad_in));
  task automatic end_of_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    if (n >= 20) end_of_test();
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask : rd
  // Move pin 2, optionally clear its flag, then read the low flags
  task automatic step(input logic lvl, input logic clr, input logic e);
    ext_lvl[2] <= lvl;
    repeat (6) @(posedge pclk);
    if (clr) wr(PEND_LO_OFS, 32'h4);
    repeat (4) @(posedge pclk);
    rd(PEND_LO_OFS, {29'h0, e, 2'h0});
  endtask : step
  initial begin : main
    logic [31:0] t;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h00C, 32'h0000_1000);
    wr(12'h00C, 32'hFFFF_FFFF);
    rd(12'h00C, 32'h02F0_7BEF);
    chk({sg[0], sm[0], pd[0], puw[0], pus[0], pad_ie[0], pad_oe[0], drv[2:0]},
      32'h1F7);
    wr(12'h00C, 32'h0000_02C1);
    wr(12'h090, 32'h0000_0041);
    wr(ODAT_LO_OFS, 32'h0000_00A5);
    wr(BSET_LO_OFS, 32'h0000_000A);
    rd(ODAT_LO_OFS, 32'h0000_00AF);
    wr(BCLR_LO_OFS, 32'h0000_000C);
    rd(ODAT_LO_OFS, 32'h0000_00A3);
    wr(BSET_HI_OFS, 32'h0000_0003);
    wr(BCLR_HI_OFS, 32'h0000_0001);
    rd(ODAT_HI_OFS, 32'h0000_0002);
    rd(BSET_LO_OFS, 32'h0);
    chk({pad_out[33], pad_out[1], pad_out[0]}, 32'h5);
    po[8] <= 1'b1;
    poe[8] <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({pad_oe[1], pad_out[1]}, 32'h3);
    ext_en <= 48'h0004_0000_000C;
    ext_lvl <= 48'h0004_0000_000C;
    wr(12'h014, 32'h0000_0081);
    wr(12'h094, 32'h0000_0081);
    rd(IDAT_LO_OFS, 32'h0000_0005);
    rd(IDAT_HI_OFS, 32'h0000_0004);
    chk({p_in[3], p_in[2]}, 32'h2);
    step(1'b0, 1'b0, 1'b0);
    // Per code: flag before, after rise, after clear, after fall
    for (int c = 0; c < 8; c++) begin
      t = 32'h000D_7514 >> (4 * c);
      wr(12'h014, 32'h0010_0081 | (32'(c) << 21) |
        (c % 2 ? 32'h0 : 32'h0200_0000));
      step(1'b0, 1'b1, t[3]);
      step(1'b1, 1'b0, t[2]);
      step(1'b1, 1'b1, t[1]);
      step(1'b0, 1'b0, t[0]);
      chk(irq_req[2], t[0] & (c % 2 == 0));
    end
    wr(EVT_CLR_OFS, 32'h3);
    wr(EVT_EN_OFS, 32'h1);
    wr(12'h014, 32'h0250_0081);
    step(1'b1, 1'b0, 1'b1);
    chk({irq, irq_req[2]}, 32'h3);
    rd(EVT_STAT_OFS, 32'h1);
    wr(EVT_EN_OFS, 32'h0);
    // irq is registered: it drops one edge after the enable write lands
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0);
    wr(EVT_EN_OFS, 32'h1);
    wr(EVT_CLR_OFS, 32'h1);
    rd(EVT_STAT_OFS, 32'h0);
    chk(irq, 32'h0);
    wr(12'h0CC, 32'hFFFF_FFFF);
    chk(err_q, 32'h1);
    rd(12'h0CC, 32'h0);
    chk(err_q, 32'h1);
    end_of_test();
  end
endmodule : gpc_gpio_pin_ctrl_tb
bind gpc_gpio_pin_ctrl gpc_gpio_pin_ctrl_assertions #(.NUM_PINS(NUM_PINS))
  u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pad_out(pad_out), .pad_oe(pad_oe), .pad_ie(pad_ie),
  .pad_schmitt(pad_schmitt), .pad_pulldown(pad_pulldown),
  .pad_pullup_weak(pad_pullup_weak), .pad_pullup_strong(pad_pullup_strong),
  .pad_drive_level(pad_drive_level), .periph_sel_gpio(periph_sel_gpio));
`default_nettype wire
